// *** sector_timing_defines.svh ***
// Timing constants, bit positions and masks of the sector timing sequencer.
// Assumes a 200 MHz system clock; all sequencer counts are in 500 ns master ticks.
`ifndef SECTOR_TIMING_DEFINES_SVH
`define SECTOR_TIMING_DEFINES_SVH

// System clock and master timing clock
`define CLK_PERIOD_PS      5000
`define MASTER_PERIOD_NS   500
`define MASTER_HALF_CYC    ((`MASTER_PERIOD_NS * 1000 / `CLK_PERIOD_PS) / 2)
`define US_TO_TICKS(us)    ((us) * 1000 / `MASTER_PERIOD_NS)

// Divider chain tap bits (bit k has a period of 2^(k+1) ticks)
`define DIV_WIDTH          16
`define TAP_8US_BIT        3
`define TAP_128US_BIT      7
`define TAP_2MS_BIT        11
`define TAP_32MS_BIT       15

// Slow prescaler and long stage
`define SLOW_PERIOD_MS     500
`define SLOW_HALF_TICKS    (`SLOW_PERIOD_MS * 1000000 / `MASTER_PERIOD_NS / 2)
`define LONG_STAGE_BIT     3

// Write path
`define WSEQ_LOW_US        96
`define WSEQ_LOW_TICKS     (16'(`US_TO_TICKS(`WSEQ_LOW_US)))
`define BITCELL_US         4
`define BITCELL_MASK       (16'(`US_TO_TICKS(`BITCELL_US) - 1))
`define WR_PULSE_NS        650
`define WR_PULSE_CYC       (8'((`WR_PULSE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS))

// Read sequencer marks after sector start
`define WINDOW_US          96
`define WINDOW_TICKS       (11'(`US_TO_TICKS(`WINDOW_US)))
`define RE_US              480
`define RE_TICKS           (11'(`US_TO_TICKS(`RE_US)))
`define ACQ_US             125
`define ACQ_END_TICKS      (11'(`US_TO_TICKS(`RE_US + `ACQ_US)))
`define DD_US              512
`define DD_TICKS           (11'(`US_TO_TICKS(`DD_US)))
`define HUNT_US            736
`define HUNT_TICKS         (11'(`US_TO_TICKS(`HUNT_US)))
`define DATA_MARKER_A_US            780
`define DATA_MARKER_A_TICKS         (11'(`US_TO_TICKS(`DATA_MARKER_A_US)))
`define BLANK_US           44
`define BLANK_END_TICKS    (11'(`US_TO_TICKS(`DATA_MARKER_A_US + `BLANK_US)))
`define TBR_SLOW_US        32
`define TBR_SLOW_TICKS     (6'(`US_TO_TICKS(`TBR_SLOW_US) - 1))
`define SEQ_MAX            11'h7ff

// Motor auto-off: one strap unit is 3.2 s, counted in 32 ms sectors
`define SECTOR_MS          32
`define MOTOR_UNIT_MS      3200
`define MOTOR_UNIT_SECTORS (11'(`MOTOR_UNIT_MS / `SECTOR_MS))

`endif

// *** sector_timing_pkg.sv ***
// Types shared by the sector timing sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package sector_timing_pkg;
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_RUN  = 2'b01,
      SEQ_HOLD = 2'b10
   } seq_state_t;
endpackage

// *** disk_sector_timing_sequencer.sv ***
// Timing generator of a floppy disk controller: divider chain, write cell
// timing, motor auto-off and the per-sector read sequencer.
// Assumes a 200 MHz clk, synchronous reset, drive signals arriving unsynchronised.
//
// Contract
// - Free-running 500 ns square master clock
// - Divider taps of 8 us and 128 us
// - Divider taps of 2 ms and 32 ms
// - Slow prescaler gives 500 ms square wave
// - Long stage after prescaler, about 8 s
// - Write taps low 96 us every 32 ms
// - All-ones write gives pulse every 4 us
// - Sector window high 96 us from start
// - Read gate rises 480 us after start
// - Acquire starts with read gate, 125 us
// - Double density flag at 512 us
// - Sync hunt enable at 736 us
// - Data window 4 us square after read gate
// - Separated bits only inside data window
// - Same sequence for double density sectors
// - Motor off after strapped delay, default 9.6 s
// - Strap-enabled pulse on each sector hole
`timescale 1ns/1ps
`include "sector_timing_defines.svh"

module disk_sector_timing_sequencer #(
   parameter int MASTER_HALF_CYC = `MASTER_HALF_CYC,
   parameter int SLOW_HALF_TICKS = `SLOW_HALF_TICKS
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // Drive side pins
   input  wire logic        sector_hole,
   input  wire logic        raw_read_pulse,
   // Controller logic and straps
   input  wire logic        disk_activity,
   input  wire logic        write_enable,
   input  wire logic        write_data,
   input  wire logic        density_double,
   input  wire logic        sync_found,
   input  wire logic [3:0]  motor_delay_units,
   input  wire logic        sector_irq_strap,
   // Divider chain
   output logic             master_clk,
   output logic             div_tap_8us,
   output logic             div_tap_128us,
   output logic             div_tap_2ms,
   output logic             div_tap_32ms,
   output logic             slow_prescale_500ms,
   output logic             slow_long_stage,
   // Write path
   output logic             write_seq_tap_a,
   output logic             write_seq_tap_b,
   output logic             write_pulse,
   // Read sequencer
   output logic             sector_window,
   output logic             read_gate,
   output logic             phase_acquire,
   output logic             double_density_flag,
   output logic             sync_hunt_en,
   output logic             twice_bitrate_clk,
   output logic             data_window,
   output logic             separated_read_bits,
   output logic             data_marker_a,
   output logic             sync_blank,
   // Motor and sector pulse
   output logic             motor_on,
   output logic             sector_irq
);

   localparam int HALF_I = MASTER_HALF_CYC;

   logic [15:0]             half_cnt_reg;
   logic                    master_clk_reg;
   logic                    tick;
   logic [`DIV_WIDTH-1:0]   div_cnt_reg;
   logic [19:0]             slow_cnt_reg;
   logic                    slow_reg;
   logic [3:0]              long_cnt_reg;
   logic [2:0]              hole_sync_reg;
   logic                    hole_stable_reg;
   logic                    hole_rise;
   logic [2:0]              rd_sync_reg;
   logic                    rd_stable_reg;
   logic                    rd_rise;
   logic [3:0]              strap_sel_reg;
   logic                    strap_irq_reg;
   logic                    strap_done_reg;
   sector_timing_pkg::seq_state_t state_reg;
   logic [10:0]             seq_reg;
   logic [5:0]              phase_reg;
   logic                    tbr_fast_reg;
   logic                    sync_seen_reg;
   logic                    in_run;
   logic [7:0]              wr_cnt_reg;
   logic [10:0]             motor_cnt_reg;
   logic [10:0]             motor_limit;

   // Master clock: half-period counter, tick once per full 500 ns period
   always_ff @(posedge clk) begin
      if (reset) begin
         half_cnt_reg   <= 16'h0000;
         master_clk_reg <= 1'b0;
      end else if (half_cnt_reg == 16'(HALF_I - 1)) begin
         half_cnt_reg   <= 16'h0000;
         master_clk_reg <= ~master_clk_reg;
      end else begin
         half_cnt_reg   <= half_cnt_reg + 16'h0001;
      end
   end
   assign tick = master_clk_reg && (half_cnt_reg == 16'(HALF_I - 1));

   // Ripple chain as one binary counter; each tap is a plain bit
   always_ff @(posedge clk) begin
      if (reset)
         div_cnt_reg <= 16'h0000;
      else if (tick)
         div_cnt_reg <= div_cnt_reg + 16'h0001;
   end

   // Slow prescaler, too long for the main chain, then the long stage
   always_ff @(posedge clk) begin
      if (reset) begin
         slow_cnt_reg <= 20'h00000;
         slow_reg     <= 1'b0;
         long_cnt_reg <= 4'h0;
      end else if (tick) begin
         if (slow_cnt_reg == 20'(SLOW_HALF_TICKS - 1)) begin
            slow_cnt_reg <= 20'h00000;
            slow_reg     <= ~slow_reg;
            if (slow_reg)
               long_cnt_reg <= long_cnt_reg + 4'h1;
         end else begin
            slow_cnt_reg <= slow_cnt_reg + 20'h00001;
         end
      end
   end

   // Drive pins: three flops, a change counts once second and third agree
   always_ff @(posedge clk) begin
      if (reset) begin
         hole_sync_reg   <= 3'h0;
         hole_stable_reg <= 1'b0;
         rd_sync_reg     <= 3'h0;
         rd_stable_reg   <= 1'b0;
      end else begin
         hole_sync_reg <= {hole_sync_reg[1:0], sector_hole};
         rd_sync_reg   <= {rd_sync_reg[1:0], raw_read_pulse};
         if (hole_sync_reg[1] == hole_sync_reg[2])
            hole_stable_reg <= hole_sync_reg[2];
         if (rd_sync_reg[1] == rd_sync_reg[2])
            rd_stable_reg <= rd_sync_reg[2];
      end
   end
   assign hole_rise = hole_sync_reg[1] && hole_sync_reg[2] && !hole_stable_reg;
   assign rd_rise   = rd_sync_reg[1] && rd_sync_reg[2] && !rd_stable_reg;

   // Straps caught once after reset release; later changes are ignored
   always_ff @(posedge clk) begin
      if (reset) begin
         strap_done_reg <= 1'b0;
         strap_sel_reg  <= 4'h3;
         strap_irq_reg  <= 1'b0;
      end else if (!strap_done_reg) begin
         strap_done_reg <= 1'b1;
         strap_sel_reg  <= motor_delay_units;
         strap_irq_reg  <= sector_irq_strap;
      end
   end

   // Divider outputs registered so every port comes from a flop
   always_ff @(posedge clk) begin
      if (reset) begin
         master_clk          <= 1'b0;
         div_tap_8us         <= 1'b0;
         div_tap_128us       <= 1'b0;
         div_tap_2ms         <= 1'b0;
         div_tap_32ms        <= 1'b0;
         slow_prescale_500ms <= 1'b0;
         slow_long_stage     <= 1'b0;
      end else begin
         master_clk          <= master_clk_reg;
         div_tap_8us         <= div_cnt_reg[`TAP_8US_BIT];
         div_tap_128us       <= div_cnt_reg[`TAP_128US_BIT];
         div_tap_2ms         <= div_cnt_reg[`TAP_2MS_BIT];
         div_tap_32ms        <= div_cnt_reg[`TAP_32MS_BIT];
         slow_prescale_500ms <= slow_reg;
         slow_long_stage     <= long_cnt_reg[`LONG_STAGE_BIT];
      end
   end

   // Write cell timing; pulses only while the write taps are high
   always_ff @(posedge clk) begin
      if (reset) begin
         write_seq_tap_a <= 1'b1;
         write_seq_tap_b <= 1'b1;
         wr_cnt_reg      <= 8'h00;
         write_pulse     <= 1'b0;
      end else begin
         write_seq_tap_a <= div_cnt_reg >= `WSEQ_LOW_TICKS;
         write_seq_tap_b <= div_cnt_reg >= `WSEQ_LOW_TICKS;
         if (tick && ((div_cnt_reg & `BITCELL_MASK) == 16'h0000) && write_enable
             && write_data && write_seq_tap_a)
            wr_cnt_reg <= `WR_PULSE_CYC;
         else if (wr_cnt_reg != 8'h00)
            wr_cnt_reg <= wr_cnt_reg - 8'h01;
         write_pulse <= (wr_cnt_reg != 8'h00);
      end
   end

   // Sector sequencer: restarts on every hole, saturates until the next
   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= sector_timing_pkg::SEQ_IDLE;
         seq_reg   <= 11'h000;
      end else if (hole_rise) begin
         state_reg <= sector_timing_pkg::SEQ_RUN;
         seq_reg   <= 11'h000;
      end else begin
         unique case (state_reg)
            sector_timing_pkg::SEQ_IDLE: seq_reg <= 11'h000;
            sector_timing_pkg::SEQ_RUN: begin
               if (tick)
                  seq_reg <= seq_reg + 11'h001;
               if (tick && seq_reg == `SEQ_MAX - 11'h001)
                  state_reg <= sector_timing_pkg::SEQ_HOLD;
            end
            sector_timing_pkg::SEQ_HOLD: seq_reg <= `SEQ_MAX;
            default: state_reg <= sector_timing_pkg::SEQ_IDLE;
         endcase
      end
   end
   assign in_run = (state_reg != sector_timing_pkg::SEQ_IDLE) && !hole_rise;

   // Sync seen latch; a find in the clearing cycle wins
   always_ff @(posedge clk) begin
      if (reset)
         sync_seen_reg <= 1'b0;
      else if (sync_hunt_en && sync_found)
         sync_seen_reg <= 1'b1;
      else if (hole_rise)
         sync_seen_reg <= 1'b0;
   end

   // Read sequencer marks, all decoded from the tick count
   always_ff @(posedge clk) begin
      if (reset) begin
         sector_window       <= 1'b0;
         read_gate           <= 1'b0;
         phase_acquire       <= 1'b0;
         double_density_flag <= 1'b0;
         sync_hunt_en        <= 1'b0;
         data_marker_a       <= 1'b0;
         sync_blank          <= 1'b0;
      end else begin
         sector_window <= in_run && seq_reg < `WINDOW_TICKS;
         read_gate     <= in_run && seq_reg >= `RE_TICKS;
         phase_acquire <= in_run && seq_reg >= `RE_TICKS
                          && seq_reg < `ACQ_END_TICKS;
         double_density_flag <= in_run && density_double
                                && seq_reg >= `DD_TICKS;
         sync_hunt_en  <= in_run && seq_reg >= `HUNT_TICKS;
         data_marker_a <= in_run && sync_seen_reg
                          && seq_reg >= `DATA_MARKER_A_TICKS;
         sync_blank    <= in_run && sync_seen_reg && seq_reg >= `DATA_MARKER_A_TICKS
                          && seq_reg < `BLANK_END_TICKS;
      end
   end

   // Bit phase after read gate; the fast flag is kept apart because the
   // six-bit phase wraps and would drop the clock back to the slow rate
   always_ff @(posedge clk) begin
      if (reset || !read_gate) begin
         phase_reg    <= 6'h00;
         tbr_fast_reg <= 1'b0;
      end else if (tick) begin
         phase_reg <= phase_reg + 6'h01;
         if (phase_reg == `TBR_SLOW_TICKS)
            tbr_fast_reg <= 1'b1;
      end
   end

   // Twice-bitrate clock, data window and separated bits
   always_ff @(posedge clk) begin
      if (reset) begin
         twice_bitrate_clk   <= 1'b0;
         data_window         <= 1'b0;
         separated_read_bits <= 1'b0;
      end else begin
         if (!read_gate)
            twice_bitrate_clk <= 1'b0;
         else if (tick && !tbr_fast_reg)
            twice_bitrate_clk <= phase_reg[2:0] == 3'h3 ? 1'b1 :
                                 phase_reg[2:0] == 3'h7 ? 1'b0 : twice_bitrate_clk;
         else if (tick)
            twice_bitrate_clk <= ~phase_reg[0] ? twice_bitrate_clk : ~twice_bitrate_clk;
         data_window <= read_gate && phase_reg[2];
         // Narrow read pulses pass only inside the open window
         separated_read_bits <= rd_rise && read_gate && data_window;
      end
   end

   // Motor auto-off in 32 ms steps; activity restarts the delay
   assign motor_limit = 11'(strap_sel_reg * `MOTOR_UNIT_SECTORS);
   always_ff @(posedge clk) begin
      if (reset) begin
         motor_on      <= 1'b0;
         motor_cnt_reg <= 11'h000;
      end else if (disk_activity) begin
         motor_on      <= 1'b1;
         motor_cnt_reg <= 11'h000;
      end else if (motor_on && tick && div_cnt_reg == 16'hffff) begin
         motor_cnt_reg <= motor_cnt_reg + 11'h001;
         if (motor_cnt_reg + 11'h001 >= motor_limit)
            motor_on <= 1'b0;
      end
   end

   // Sector hole pulse when strapped on
   always_ff @(posedge clk) begin
      if (reset)
         sector_irq <= 1'b0;
      else
         sector_irq <= hole_rise && strap_irq_reg;
   end

   // Checks
   property p_master_half;
      @(posedge clk) disable iff (reset)
      $rose(master_clk_reg) |-> ##HALF_I $fell(master_clk_reg);
   endproperty
   a_master_half: assert property (p_master_half)
      else $error("master clock half period wrong");

   property p_window_end;
      @(posedge clk) disable iff (reset)
      $fell(sector_window) |-> (seq_reg == `WINDOW_TICKS) || $past(hole_rise);
   endproperty
   a_window_end: assert property (p_window_end)
      else $error("sector window ended at wrong time");

   property p_read_gate;
      @(posedge clk) disable iff (reset)
      $rose(read_gate) |-> seq_reg == `RE_TICKS && phase_acquire;
   endproperty
   a_read_gate: assert property (p_read_gate)
      else $error("read gate rose at wrong time");

   property p_acq_end;
      @(posedge clk) disable iff (reset)
      $fell(phase_acquire) && read_gate |-> seq_reg == `ACQ_END_TICKS;
   endproperty
   a_acq_end: assert property (p_acq_end)
      else $error("acquire length wrong");

   property p_dd;
      @(posedge clk) disable iff (reset)
      $rose(double_density_flag) |-> read_gate && seq_reg >= `DD_TICKS;
   endproperty
   a_dd: assert property (p_dd)
      else $error("double density flag early");

   property p_hunt;
      @(posedge clk) disable iff (reset)
      $rose(sync_hunt_en) |-> seq_reg == `HUNT_TICKS;
   endproperty
   a_hunt: assert property (p_hunt)
      else $error("hunt enable at wrong time");

   property p_data_marker_a;
      @(posedge clk) disable iff (reset)
      $rose(data_marker_a) |-> $rose(sync_blank) && seq_reg >= `DATA_MARKER_A_TICKS;
   endproperty
   a_data_marker_a: assert property (p_data_marker_a)
      else $error("marker and blank not together");

   property p_tbr_low;
      @(posedge clk) disable iff (reset)
      !read_gate |=> !twice_bitrate_clk && !data_window;
   endproperty
   a_tbr_low: assert property (p_tbr_low)
      else $error("bit clock runs without read gate");

   property p_wseq;
      @(posedge clk) disable iff (reset)
      !write_seq_tap_a |-> $past(div_cnt_reg) < `WSEQ_LOW_TICKS;
   endproperty
   a_wseq: assert property (p_wseq)
      else $error("write tap low outside window");

endmodule // disk_sector_timing_sequencer

// *** sector_drive_model.sv ***
// Behavioural floppy drive: sector hole and raw read pulses on the ribbon cable.
// Assumes the bench asks for each hole and turns the read stream on and off.
`timescale 1ns/1ps
module sector_drive_model (
   // Clock
   input  wire logic clk,
   // Requests from the bench
   input  wire logic hole_req,
   input  wire logic read_on,
   // Drive pins
   output logic      sector_hole,
   output logic      raw_read_pulse
);
   int hole_cnt = 0;
   int bit_cnt = 0;

   initial begin
      sector_hole = 1'b0;
      raw_read_pulse = 1'b0;
   end

   // Hole held 40 clk, well past the three-stage sync
   always @(posedge clk) begin
      if (hole_req) hole_cnt <= 40;
      else if (hole_cnt > 0) hole_cnt <= hole_cnt - 1;
      sector_hole <= hole_req || (hole_cnt > 1);
   end

   // Zero-bit stream carries clock pulses only; 3 clk wide so the sync sees them
   always @(posedge clk) begin
      bit_cnt <= (bit_cnt + 1) % 16;
      raw_read_pulse <= read_on && (bit_cnt < 3);
   end
endmodule // sector_drive_model

// *** disk_sector_timing_sequencer_tb_top.sv ***
// Self-checking bench of the sector timing sequencer with a drive model.
// Assumes shortened timing: MASTER_HALF_CYC 2 (one tick is 4 clk), SLOW_HALF_TICKS 4.
`timescale 1ns/1ps
module disk_sector_timing_sequencer_tb_top;
   logic clk, reset, disk_activity, write_enable, write_data, density_double, sync_found;
   logic [3:0] motor_delay_units;
   logic sector_irq_strap, hole_req, read_on, sector_hole, raw_read_pulse;
   logic master_clk, div_tap_8us, div_tap_128us, div_tap_2ms, div_tap_32ms;
   logic slow_prescale_500ms, slow_long_stage, write_seq_tap_a, write_seq_tap_b;
   logic write_pulse, sector_window, read_gate, phase_acquire, double_density_flag;
   logic sync_hunt_en, twice_bitrate_clk, data_window, separated_read_bits;
   logic data_marker_a, sync_blank, motor_on, sector_irq;
   logic [21:0] obs;
   int n_fail = 0;
   int check_count = 0;
   int cyc = 0;
   int sep_n = 0;
   int irq_n = 0;

   // Outputs gathered so waits can pick one by index
   assign obs = {div_tap_32ms, div_tap_2ms, sector_irq, separated_read_bits, write_seq_tap_b,
                 motor_on, write_pulse, sync_blank, data_marker_a, data_window,
                 twice_bitrate_clk, sync_hunt_en, double_density_flag, phase_acquire,
                 read_gate, sector_window, write_seq_tap_a, slow_long_stage,
                 slow_prescale_500ms, div_tap_128us, div_tap_8us, master_clk};

   disk_sector_timing_sequencer #(.MASTER_HALF_CYC(2), .SLOW_HALF_TICKS(4))
   disk_sector_timing_sequencer_inst (
      .clk(clk), .reset(reset), .sector_hole(sector_hole), .raw_read_pulse(raw_read_pulse),
      .disk_activity(disk_activity), .write_enable(write_enable), .write_data(write_data),
      .density_double(density_double), .sync_found(sync_found),
      .motor_delay_units(motor_delay_units), .sector_irq_strap(sector_irq_strap),
      .master_clk(master_clk), .div_tap_8us(div_tap_8us), .div_tap_128us(div_tap_128us),
      .div_tap_2ms(div_tap_2ms), .div_tap_32ms(div_tap_32ms),
      .slow_prescale_500ms(slow_prescale_500ms), .slow_long_stage(slow_long_stage),
      .write_seq_tap_a(write_seq_tap_a), .write_seq_tap_b(write_seq_tap_b),
      .write_pulse(write_pulse), .sector_window(sector_window), .read_gate(read_gate),
      .phase_acquire(phase_acquire), .double_density_flag(double_density_flag),
      .sync_hunt_en(sync_hunt_en), .twice_bitrate_clk(twice_bitrate_clk),
      .data_window(data_window), .separated_read_bits(separated_read_bits),
      .data_marker_a(data_marker_a), .sync_blank(sync_blank), .motor_on(motor_on),
      .sector_irq(sector_irq));

   sector_drive_model sector_drive_model_inst (
      .clk(clk), .hole_req(hole_req), .read_on(read_on),
      .sector_hole(sector_hole), .raw_read_pulse(raw_read_pulse));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic summarize();
      if (n_fail == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Compare with a tolerance in clk; tolerance 0 is an exact match
   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp, input int tol);
      int d;
      check_count++;
      d = (seen > exp) ? seen - exp : exp - seen;
      if ($isunknown(seen) || d > tol) begin
         n_fail++;
         $display("mismatch %s expected %0d seen %0d", name, exp, seen);
      end
   endtask

   // Bounded wait for one output to reach a level; returns the cycle stamp
   task automatic wait_bit(input int idx, input logic val, input int bound, output int stamp);
      int k;
      k = 0;
      while (obs[idx] !== val && k < bound) begin
         @(posedge clk);
         k++;
      end
      if (obs[idx] !== val) begin
         n_fail++;
         $display("mismatch wait on output %0d expected %b seen timeout", idx, val);
         summarize();
      end
      stamp = cyc;
   endtask

   task automatic rise(input int idx, input int bound, output int stamp);
      int s;
      wait_bit(idx, 1'b0, bound, s);
      wait_bit(idx, 1'b1, bound, stamp);
   endtask

   // Cycle stamp and read-side monitors
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (sector_irq === 1'b1) irq_n++;
      if (separated_read_bits === 1'b1) begin
         sep_n++;
         check("read bits gate", read_gate, 1, 0);
      end
   end

   task automatic t_write();
      int a, b, c, wp;
      wp = 0;
      write_enable <= 1'b1;
      write_data <= 1'b1;
      wait_bit(5, 1'b0, 64, a);
      check("write tap b", obs[17], 0, 0);
      while (obs[5] !== 1'b1 && wp < 2000) begin
         if (obs[15] === 1'b1) wp = wp + 1000;
         @(posedge clk);
         wp++;
      end
      b = cyc;
      check("write tap low", b - a, 768, 4);
      wait_bit(15, 1'b1, 80, c);
      write_data <= 1'b0;
      check("pulse after tap", c - b, 17, 17);
      wait_bit(15, 1'b0, 200, a);
      check("pulse width", a - c, 130, 2);
   endtask

   task automatic t_dividers();
      int idx[5] = '{0, 1, 2, 3, 4};
      int per[5] = '{4, 64, 1024, 32, 512};
      int a, b;
      foreach (idx[i]) begin
         rise(idx[i], 1100, a);
         rise(idx[i], 1100, b);
         check($sformatf("period of output %0d", idx[i]), b - a, per[i], 0);
      end
      rise(20, 17000, a);
      rise(20, 17000, b);
      check("period of 2 ms tap", b - a, 16384, 0);
   endtask

   task automatic t_motor();
      check("motor idle", obs[16], 0, 0);
      @(posedge clk);
      disk_activity <= 1'b1;
      @(posedge clk);
      disk_activity <= 1'b0;
      @(posedge clk);
      check("motor on", obs[16], 1, 0);
   endtask

   task automatic t_sector(input logic dd, input logic sync);
      int t0, t, tre, a, b, irq0;
      irq0 = irq_n;
      sep_n = 0;
      density_double <= dd;
      sync_found <= sync;
      read_on <= 1'b1;
      @(posedge clk);
      hole_req <= 1'b1;
      @(posedge clk);
      hole_req <= 1'b0;
      wait_bit(6, 1'b1, 100, t0);
      check("bitrate clk idle", obs[11], 0, 0);
      wait_bit(6, 1'b0, 1000, t);
      check("window width", t - t0, 768, 4);
      wait_bit(7, 1'b1, 4000, tre);
      check("read gate", tre - t0, 3840, 4);
      check("acquire start", obs[8], 1, 0);
      rise(11, 100, a);
      rise(11, 100, b);
      check("bitrate slow period", b - a, 32, 0);
      if (dd) begin
         wait_bit(9, 1'b1, 400, t);
         check("density flag", t - t0, 4096, 4);
      end
      while (cyc < tre + 300) @(posedge clk);
      rise(11, 100, a);
      rise(11, 100, b);
      check("bitrate fast period", b - a, 16, 0);
      wait_bit(8, 1'b0, 1200, t);
      check("acquire width", t - tre, 1000, 200);
      wait_bit(10, 1'b1, 3000, t);
      check("hunt enable", t - t0, 5888, 4);
      rise(12, 100, a);
      rise(12, 100, b);
      check("data window period", b - a, 32, 0);
      if (sync) begin
         wait_bit(13, 1'b1, 600, t);
         check("marker", t - t0, 6240, 4);
         check("blank start", obs[14], 1, 0);
         wait_bit(14, 1'b0, 500, b);
         check("blank width", b - t, 352, 48);
      end else begin
         repeat (500) @(posedge clk);
         check("no marker", obs[13], 0, 0);
      end
      check("density level", obs[9], dd, 0);
      check("read bits seen", sep_n > 0, 1, 0);
      check("sector pulse", irq_n - irq0, 1, 0);
      read_on <= 1'b0;
   endtask

   // Hang guard
   initial begin
      repeat (100000) @(posedge clk);
      n_fail++;
      $display("mismatch run length expected finish seen timeout");
      summarize();
   end

   initial begin
      reset = 1'b1;
      disk_activity = 1'b0;
      write_enable = 1'b0;
      write_data = 1'b0;
      density_double = 1'b0;
      sync_found = 1'b0;
      motor_delay_units = 4'h3;
      sector_irq_strap = 1'b1;
      hole_req = 1'b0;
      read_on = 1'b0;
      repeat (9) @(posedge clk);
      check("reset outputs", obs, 32'h020020, 0);
      @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      t_write();
      t_dividers();
      t_motor();
      t_sector(1'b1, 1'b1);
      t_sector(1'b0, 1'b0);
      summarize();
   end
endmodule // disk_sector_timing_sequencer_tb_top
